// ---- hw/ffmc_pkg.sv ----
// Package: constants and carrier types for the fixed frame message codec
package ffmc_pkg;
  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  localparam logic [7:0] FFMC_START = 8'h7e; // Opening byte
  localparam logic [7:0] FFMC_END = 8'h7f; // Closing byte
  localparam logic [7:0] FFMC_TYPE_RELAY = 8'h03; // Relay command type
  localparam logic [7:0] FFMC_TYPE_DIST = 8'h16; // Distance data type
  localparam logic [7:0] FFMC_TYPE_LOAD = 8'h25; // Load data type
  // x16+x15+x2+1, bit-reversed because the check is shifted LSB first
  localparam logic [15:0] FFMC_CRC_POLY = 16'ha001;
  localparam logic [15:0] FFMC_CRC_INIT = 16'h0000; // Register seed
  localparam int FFMC_FRAME_LEN = 47; // Default fixed frame length
  localparam int FFMC_RELAY_LEN = 9; // Meaningful relay bytes
  localparam int FFMC_LOAD_LEN = 11; // Meaningful load bytes
  localparam int FFMC_DIST_LEN = 47; // Distance message bytes
  // Byte positions in a frame
  localparam logic [5:0] FFMC_POS_TYPE = 6'h01;
  localparam logic [5:0] FFMC_POS_ERR = 6'h16; // Error field, byte 22
  localparam logic [5:0] FFMC_POS_CRC = 6'h2c; // Check field, byte 44
  localparam logic [5:0] FFMC_POS_LAST = 6'h2e; // End byte, byte 46
  // Address layout
  localparam int FFMC_STN_LSB = 11;
  localparam int FFMC_GRP_LSB = 1;
  localparam logic [4:0] FFMC_DIST_STATION = 5'h02; // Source station
  // Distance error codes
  localparam logic [15:0] FFMC_ERR_OK = 16'h0000;
  localparam logic [15:0] FFMC_ERR_NOSIG = 16'h0001;
  localparam logic [15:0] FFMC_ERR_WEAK = 16'h0002;
  localparam logic [15:0] FFMC_ERR_SPEED = 16'h0004;
  localparam logic [15:0] FFMC_ERR_FAIL = 16'h0005;
  localparam logic [15:0] FFMC_ERR_RANGE = 16'h0014;
  localparam logic [15:0] FFMC_ERR_SYNC0 = 16'h0015;
  localparam logic [15:0] FFMC_ERR_SYNC1 = 16'h0016;
  localparam logic [15:0] FFMC_ERR_SYNC2 = 16'h0019;
  localparam logic [15:0] FFMC_ERR_SYNC3 = 16'h0020;
  localparam logic [15:0] FFMC_ERR_OUTLIER = 16'h00fe;
  localparam logic [15:0] FFMC_ERR_NODATA = 16'hffff;

  // Measurement handed in for transmission
  typedef struct packed {
    logic [9:0] groupNumber; // Own group
    logic signed [31:0] distance; // mm
    logic signed [31:0] velocity; // mm/s
    logic signed [15:0] level; // dB/10
    logic [15:0] errCode; // Status code
  } ffmc_meas_type;

  // Decoded load data
  typedef struct packed {
    logic [15:0] srcAddr;
    logic hasLimit; // Flag bit 0
    logic limitState; // Flag bit 1
    logic shapesValid; // Flag bit 2
    logic heightValid; // Flag bit 3
    logic [7:0] inactiveShapes; // 1 = shape inactive
    logic [15:0] height; // cm, 0 = top
  } ffmc_load_type;

  // Frame parser states
  typedef enum logic [2:0] {
    FFMC_RX_IDLE = 3'b001,
    FFMC_RX_BODY = 3'b010,
    FFMC_RX_PAD = 3'b100
  } ffmc_rx_type;
endpackage

// ---- hw/ffmc_codec.sv ----
// Fixed frame message codec: relay and load parser, distance framer
`timescale 1ns/1ps
// Function
// - Frames open 0x7e, close 0x7f, type second
// - CRC-16 over type and data bytes
// - Multi-byte fields sent most significant first
// - Relay command type 0x03, nine bytes
// - Only selected relays change state
// - No acknowledgment for relay commands
// - Distance message type 0x16 and layout
// - Distance message exactly 47 bytes
// - Load flag bits decoded as documented
// - Shape mask one means inactive
// - Height in centimetres, zero at top
// - Address: station 15..11, group 10..1
// - Distance source station always two
// - Distance error codes for measurement status
// - Sync, outlier and no-data error codes
module ffmc_codec
  import ffmc_pkg::*;
#(
  parameter int FRAME_LEN = FFMC_FRAME_LEN, // Fixed frame length
  parameter int RELAYS = 8 // Relay outputs
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn, // Low freezes all state
  input wire logic [7:0] rxData, // Byte from host stream
  input wire logic rxValid,
  input wire logic [15:0] ownAddr, // Address this unit answers to
  input wire logic [RELAYS-1:0] relayInit, // Relay levels after reset
  input wire ffmc_meas_type meas, // Measurement to send
  input wire logic measValid, // Request one distance message
  output logic measReady, // Framer idle
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic [RELAYS-1:0] relayState,
  output ffmc_load_type loadData,
  output logic loadStrobe, // One cycle per accepted load frame
  output logic frameDrop // One cycle per known-type frame with bad end byte or check
);
  // ---------------------------------------------------------------
  // CRC step
  // ---------------------------------------------------------------
  // Reflected CRC, LSB first, polynomial x16+x15+x2+1
  // The host runs the reflected form; an MSB-first shift would disagree
  // on every nonzero check and drop every frame
  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      if (r[0]) begin
        r = {1'b0, r[15:1]} ^ FFMC_CRC_POLY;
      end else begin
        r = {1'b0, r[15:1]};
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Receive parser
  // ---------------------------------------------------------------
  ffmc_rx_type rxState_r; // Parser state
  logic [5:0] rxPos_r; // Byte index in frame
  logic [7:0] rxType_r; // Type of frame in flight
  logic [7:0] rxBuf_r [0:7]; // Bytes 2..9 of the frame
  logic [15:0] rxCrc_r; // Running check over type and data
  logic [15:0] rxGot_r; // Received check field
  logic [5:0] rxLen; // Meaningful length of current type
  logic rxOk; // End and check acceptable
  logic rxEndPos; // Byte carries the end marker
  logic [5:0] dataEnd; // First check byte index

  always_comb begin
    rxLen = (rxType_r == FFMC_TYPE_RELAY) ? 6'(FFMC_RELAY_LEN)
                                          : 6'(FFMC_LOAD_LEN);
    dataEnd = rxLen - 6'h03;
    rxEndPos = (rxPos_r == rxLen - 6'h01);
    // Zero check value is accepted as valid
    rxOk = (rxData == FFMC_END) &&
           ((rxGot_r == 16'h0000) || (rxGot_r == rxCrc_r));
  end

  // Parser sequencing: start byte, known type, fixed-length tail
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxState_r <= FFMC_RX_IDLE;
      rxPos_r <= 6'h00;
      rxType_r <= 8'h00;
    end else if (clkEn && rxValid) begin
      case (rxState_r)
        FFMC_RX_IDLE: begin
          if (rxData == FFMC_START) begin
            rxState_r <= FFMC_RX_BODY;
            rxPos_r <= FFMC_POS_TYPE;
          end
        end
        FFMC_RX_BODY: begin
          rxPos_r <= rxPos_r + 6'h01;
          if (rxPos_r == FFMC_POS_TYPE) begin
            rxType_r <= rxData;
            // Unknown types are swallowed as padding
            if (rxData != FFMC_TYPE_RELAY && rxData != FFMC_TYPE_LOAD) begin
              rxState_r <= FFMC_RX_PAD;
            end
          end else if (rxEndPos) begin
            rxState_r <= FFMC_RX_PAD;
          end
        end
        FFMC_RX_PAD: begin
          // Host pads to the fixed length; skip the rest
          rxPos_r <= rxPos_r + 6'h01;
          if (rxPos_r == 6'(FRAME_LEN - 1)) begin
            rxState_r <= FFMC_RX_IDLE;
          end
        end
        default: rxState_r <= FFMC_RX_IDLE;
      endcase
    end
  end

  // Check accumulation and field capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxCrc_r <= FFMC_CRC_INIT;
      rxGot_r <= 16'h0000;
      for (int i = 0; i < 8; i++) begin
        rxBuf_r[i] <= 8'h00;
      end
    end else if (clkEn && rxValid && rxState_r == FFMC_RX_BODY) begin
      if (rxPos_r < dataEnd || rxPos_r == FFMC_POS_TYPE) begin
        rxCrc_r <= crcStep(rxPos_r == FFMC_POS_TYPE ? FFMC_CRC_INIT
                                                    : rxCrc_r, rxData);
      end else if (!rxEndPos) begin
        rxGot_r <= {rxGot_r[7:0], rxData};
      end
      if (rxPos_r >= 6'h02 && rxPos_r < 6'h0a) begin
        rxBuf_r[3'(rxPos_r - 6'h02)] <= rxData;
      end
    end
  end

  // ---------------------------------------------------------------
  // Relay and load outputs
  // ---------------------------------------------------------------
  logic frameDone; // End byte position reached
  logic [15:0] dstAddr; // Address field, high byte first
  assign frameDone = clkEn && rxValid && rxState_r == FFMC_RX_BODY &&
                     rxPos_r != FFMC_POS_TYPE && rxEndPos;
  assign dstAddr = {rxBuf_r[0], rxBuf_r[1]};

  // Relay update; no answer frame is ever queued
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      relayState <= relayInit;
    end else if (frameDone && rxOk && rxType_r == FFMC_TYPE_RELAY &&
                 dstAddr == ownAddr) begin
      relayState <= (relayState & ~rxBuf_r[2][RELAYS-1:0]) |
                    (rxBuf_r[2][RELAYS-1:0] & rxBuf_r[3][RELAYS-1:0]);
    end
  end

  // Load capture and event pulses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loadData <= '0;
      loadStrobe <= 1'b0;
      frameDrop <= 1'b0;
    end else if (clkEn) begin
      loadStrobe <= frameDone && rxOk && rxType_r == FFMC_TYPE_LOAD;
      frameDrop <= frameDone && !rxOk;
      if (frameDone && rxOk && rxType_r == FFMC_TYPE_LOAD) begin
        loadData.srcAddr <= dstAddr;
        loadData.hasLimit <= rxBuf_r[2][0];
        loadData.limitState <= rxBuf_r[2][1];
        loadData.shapesValid <= rxBuf_r[2][2];
        loadData.heightValid <= rxBuf_r[2][3];
        loadData.inactiveShapes <= rxBuf_r[3];
        loadData.height <= {rxBuf_r[4], rxBuf_r[5]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Distance framer
  // ---------------------------------------------------------------
  logic txBusy_r; // Frame in progress
  logic [5:0] txPos_r; // Byte being offered
  logic [15:0] txCrc_r; // Running check
  logic [7:0] txHold_r [0:16]; // Bytes 2..18 latched
  logic [15:0] txErr_r; // Error field
  logic [7:0] txByte; // Byte at txPos_r

  assign measReady = !txBusy_r;

  // Byte selection by position; reserved bytes are zero
  always_comb begin
    txByte = 8'h00;
    if (txPos_r == 6'h00) begin
      txByte = FFMC_START;
    end else if (txPos_r == FFMC_POS_TYPE) begin
      txByte = FFMC_TYPE_DIST;
    end else if (txPos_r < 6'h13) begin
      txByte = txHold_r[5'(txPos_r - 6'h02)];
    end else if (txPos_r == FFMC_POS_ERR) begin
      txByte = txErr_r[15:8];
    end else if (txPos_r == FFMC_POS_ERR + 6'h01) begin
      txByte = txErr_r[7:0];
    end else if (txPos_r == FFMC_POS_CRC) begin
      txByte = txCrc_r[15:8];
    end else if (txPos_r == FFMC_POS_CRC + 6'h01) begin
      txByte = txCrc_r[7:0];
    end else if (txPos_r == FFMC_POS_LAST) begin
      txByte = FFMC_END;
    end
  end

  // Output byte register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txData <= 8'h00;
      txValid <= 1'b0;
    end else if (clkEn) begin
      if (txValid && !txReady) begin
        txValid <= 1'b1;
      end else begin
        txValid <= txBusy_r;
        txData <= txByte;
      end
    end
  end

  // Position, check and payload latch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txBusy_r <= 1'b0;
      txPos_r <= 6'h00;
      txCrc_r <= FFMC_CRC_INIT;
      txErr_r <= FFMC_ERR_NODATA;
      for (int i = 0; i < 17; i++) begin
        txHold_r[i] <= 8'h00;
      end
    end else if (clkEn) begin
      if (!txBusy_r) begin
        if (measValid) begin
          txBusy_r <= 1'b1;
          txPos_r <= 6'h00;
          txCrc_r <= FFMC_CRC_INIT;
          txErr_r <= meas.errCode;
          {txHold_r[0], txHold_r[1]} <= {FFMC_DIST_STATION,
              meas.groupNumber, 1'b0};
          {txHold_r[2], txHold_r[3], txHold_r[4], txHold_r[5]} <=
              meas.distance;
          {txHold_r[6], txHold_r[7], txHold_r[8], txHold_r[9]} <=
              meas.velocity;
          {txHold_r[10], txHold_r[11]} <= meas.level;
          for (int i = 12; i < 17; i++) begin
            txHold_r[i] <= 8'h00;
          end
        end
      end else if (!(txValid && !txReady)) begin
        txPos_r <= txPos_r + 6'h01;
        if (txPos_r >= FFMC_POS_TYPE && txPos_r < FFMC_POS_CRC) begin
          txCrc_r <= crcStep(txCrc_r, txByte);
        end
        if (txPos_r == FFMC_POS_LAST) begin
          txBusy_r <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_relay_unselected: assert property (
    @(posedge clk_sys) disable iff (rst)
    frameDone && rxType_r == FFMC_TYPE_RELAY |=>
      ((relayState ^ $past(relayState)) & ~$past(rxBuf_r[2][RELAYS-1:0]))
      == '0)
    else $error("Unselected relay changed");
  a_frame_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    clkEn && !txBusy_r && measValid |=> txPos_r == 6'h00 && txBusy_r)
    else $error("Frame start mislaid");
  a_bad_drop: assert property (
    @(posedge clk_sys) disable iff (rst)
    frameDone && !rxOk |=> frameDrop && !loadStrobe)
    else $error("Bad frame not dropped");
  a_end_byte: assert property (
    @(posedge clk_sys) disable iff (rst)
    clkEn && txBusy_r && txPos_r == FFMC_POS_LAST && !(txValid && !txReady)
    |=> txData == FFMC_END && !txBusy_r)
    else $error("End byte wrong");
  // A good load frame must always be reported to the consumer
  a_load_strobe: assert property (
    @(posedge clk_sys) disable iff (rst)
    frameDone && rxOk && rxType_r == FFMC_TYPE_LOAD |=> loadStrobe)
    else $error("Load frame not reported");
  // A stalled byte must stay put, or the frame loses its fixed length
  a_tx_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("Offered byte changed while stalled");
endmodule // ffmc_codec

// ---- tb/ffmc_host_model.sv ----
// Host model: sends padded frames, collects framer bytes
`timescale 1ns/1ps
module ffmc_host_model
  import ffmc_pkg::*;
(
  input wire logic clk_sys,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  logic slow; // Stall every other cycle when set
  logic [7:0] got[$]; // Bytes taken from the framer
  // ------------------------------------------------------------
  // Check value, reflected: shifted LSB first, one byte at a time
  // ------------------------------------------------------------
  function automatic logic [15:0] crc16(logic [7:0] b[$], int lo, int hi);
    logic [15:0] c;
    c = FFMC_CRC_INIT;
    for (int i = lo; i <= hi; i++) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ FFMC_CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction
  // ------------------------------------------------------------
  // One frame; mode 1 zero check, 2 bad check, 3 bad end byte
  // ------------------------------------------------------------
  task automatic send(logic [7:0] typ, logic [7:0] body[$], int mode);
    logic [7:0] f[$];
    logic [15:0] c;
    f = {FFMC_START, typ, body};
    c = crc16(f, 1, f.size() - 1);
    if (mode == 1) c = 16'h0000;
    if (mode == 2) c = c ^ 16'h0100;
    f.push_back(c[15:8]);
    f.push_back(c[7:0]);
    f.push_back((mode == 3) ? 8'h55 : FFMC_END);
    while (f.size() < FFMC_FRAME_LEN) f.push_back(8'h00);
    foreach (f[i]) begin
      @(negedge clk_sys);
      rxData <= f[i];
      rxValid <= 1'b1;
    end
    @(negedge clk_sys);
    rxValid <= 1'b0;
    // Idle line shows a changed value so stale data cannot pass
    rxData <= ~f[f.size() - 1];
  endtask
  // Collect what the framer hands over
  always @(posedge clk_sys) begin
    if (txValid && txReady) begin
      got.push_back(txData);
    end
  end
  // Back-pressure: always ready, or toggling to stall the framer
  always @(negedge clk_sys) begin
    txReady <= slow ? ~txReady : 1'b1;
  end
  initial begin
    slow = 1'b0;
    rxData = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b1;
  end
endmodule // ffmc_host_model

// ---- tb/fixed_frame_message_codec_tb.sv ----
// Testbench for the fixed frame message codec
`timescale 1ns/1ps
module fixed_frame_message_codec_tb;
  import ffmc_pkg::*;
  logic clk_sys, rst, measValid, measReady, txValid, txReady, rxValid;
  logic loadStrobe, frameDrop;
  logic [7:0] rxData, txData, relayState;
  logic [15:0] ownAddr; // Station 1, group 0x155
  ffmc_meas_type meas;
  ffmc_load_type loadData;
  int failCount = 0, totalChecks = 0, dropCount = 0, loadCount = 0;
  // ------------------------------------------------------------
  // Clock, device and host
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  ffmc_codec ffmc_codec_i (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1),
    .rxData(rxData), .rxValid(rxValid), .ownAddr(ownAddr),
    .relayInit(8'h00), .meas(meas), .measValid(measValid),
    .measReady(measReady), .txData(txData), .txValid(txValid),
    .txReady(txReady), .relayState(relayState), .loadData(loadData),
    .loadStrobe(loadStrobe), .frameDrop(frameDrop));
  ffmc_host_model ffmc_host_model_i (.clk_sys(clk_sys), .rxData(rxData),
    .rxValid(rxValid), .txData(txData), .txValid(txValid),
    .txReady(txReady));
  // Pulse counters, so no pulse is missed between checks
  always @(posedge clk_sys) begin
    if (frameDrop === 1'b1) dropCount++;
    if (loadStrobe === 1'b1) loadCount++;
  end
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic relay(logic [15:0] a, logic [7:0] sel, logic [7:0] sw,
    int mode, logic [7:0] exp, int drops);
    logic [7:0] b[$];
    int d0;
    d0 = dropCount;
    b = '{a[15:8], a[7:0], sel, sw};
    ffmc_host_model_i.send(FFMC_TYPE_RELAY, b, mode);
    repeat (2) @(negedge clk_sys);
    chk("relay state", exp, relayState);
    chk("drop pulses", drops, dropCount - d0);
    chk("tx bytes", 0, ffmc_host_model_i.got.size());
  endtask
  task automatic test_relay;
    relay(16'h0aaa, 8'h14, 8'hff, 0, 8'h14, 0);
    relay(16'h0aaa, 8'h11, 8'h01, 0, 8'h05, 0);
    relay(16'h12aa, 8'hff, 8'hff, 0, 8'h05, 0);
    relay(16'haa0a, 8'hff, 8'hff, 0, 8'h05, 0);
    relay(16'h0aaa, 8'hff, 8'hff, 2, 8'h05, 1);
    relay(16'h0aaa, 8'hff, 8'hff, 3, 8'h05, 1);
    relay(16'h0aaa, 8'h80, 8'h80, 1, 8'h85, 0);
    $display("test_relay done");
  endtask
  task automatic load(logic [7:0] b[$], ffmc_load_type exp);
    int l0;
    l0 = loadCount;
    ffmc_host_model_i.send(FFMC_TYPE_LOAD, b, 0);
    repeat (2) @(negedge clk_sys);
    chk("load data", exp, loadData);
    chk("load pulses", 1, loadCount - l0);
  endtask
  task automatic test_load;
    load('{8'h12, 8'h34, 8'h0d, 8'h0e, 8'h01, 8'h23},
      '{16'h1234, 1'b1, 1'b0, 1'b1, 1'b1, 8'h0e, 16'h0123});
    load('{8'h10, 8'h02, 8'hf2, 8'hf1, 8'h00, 8'h00},
      '{16'h1002, 1'b0, 1'b1, 1'b0, 1'b0, 8'hf1, 16'h0000});
    $display("test_load done");
  endtask
  // Every error code, alternately with the sink stalling
  task automatic test_dist;
    logic [15:0] codes[12];
    logic [7:0] e[$];
    int n;
    codes = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0005, 16'h0014,
      16'h0015, 16'h0016, 16'h0019, 16'h0020, 16'h00fe, 16'hffff};
    // Anchor the model's check against a known one-byte frame body
    e = {8'h02};
    chk("crc reference", 16'hc181, ffmc_host_model_i.crc16(e, 0, 0));
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_sys);
      ffmc_host_model_i.slow = i[0];
      ffmc_host_model_i.got.delete();
      meas = '{10'h2a5, 32'hffff_fc18 + i, 32'h0000_1f40 - i, 16'hff9c,
        codes[i]};
      for (n = 0; n < 200 && measReady !== 1'b1; n++) @(negedge clk_sys);
      measValid <= 1'b1;
      @(negedge clk_sys);
      measValid <= 1'b0;
      for (n = 0; n < 400 && ffmc_host_model_i.got.size() < 47; n++)
        @(negedge clk_sys);
      repeat (4) @(negedge clk_sys);
      e = {};
      repeat (47) e.push_back(8'h00);
      e[0] = FFMC_START;
      e[1] = FFMC_TYPE_DIST;
      {e[2], e[3]} = {5'h02, meas.groupNumber, 1'b0};
      {e[4], e[5], e[6], e[7]} = meas.distance;
      {e[8], e[9], e[10], e[11]} = meas.velocity;
      {e[12], e[13]} = meas.level;
      {e[22], e[23]} = codes[i];
      {e[44], e[45]} = ffmc_host_model_i.crc16(e, 1, 43);
      e[46] = FFMC_END;
      chk("tx length", 47, ffmc_host_model_i.got.size());
      foreach (e[j]) chk("tx byte", e[j], ffmc_host_model_i.got[j]);
    end
    $display("test_dist done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog: tests need well under 6000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    measValid = 1'b0;
    ownAddr = 16'h0aaa;
    meas = '0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("reset relays", 0, relayState);
    test_relay;
    test_load;
    test_dist;
    final_report;
  end
endmodule // fixed_frame_message_codec_tb
